// *** design/gate_timer_map.svh ***
// Register offsets, field positions, reset values and timing constants
`ifndef GATE_TIMER_MAP_SVH
`define GATE_TIMER_MAP_SVH

`define CLK_CTRL_OFFSET 12'h000
`define GATE_CTRL_OFFSET 12'h004
`define COUNT_LOW_OFFSET 12'h008
`define COUNT_HIGH_OFFSET 12'h00C
`define FLAGS_OFFSET 12'h010

`define CLK_CTRL_RESET 8'h00
`define GATE_CTRL_RESET 8'h00
`define CLK_CTRL_WMASK 8'hF5

`define CS_MSB 7
`define CS_LSB 6
`define PS_MSB 5
`define PS_LSB 4
`define SYNC_DIS_BIT 2
`define ON_BIT 0

`define GE_BIT 7
`define GPOL_BIT 6
`define GTM_BIT 5
`define GSPM_BIT 4
`define GGO_BIT 3
`define GVAL_BIT 2
`define GSS_MSB 1
`define GSS_LSB 0

`define OVF_FLAG_BIT 0
`define GATE_FLAG_BIT 1

`define INSTR_DIV 4

`endif

// *** design/gate_timer_pkg.sv ***
// Types shared by the gated timer files
package gate_timer_pkg;
  typedef enum logic [3:0] {
    CLK_INSTR = 4'h1,
    CLK_SYS = 4'h2,
    CLK_EXT = 4'h4,
    CLK_OSC = 4'h8
  } clk_src_t;

  typedef enum logic [2:0] {
    SP_IDLE = 3'h1,
    SP_ARMED = 3'h2,
    SP_RUN = 3'h4
  } sp_state_t;
endpackage

// *** design/edge_if.sv ***
// Edge strobes passed between the timer core and its edge detectors
`timescale 1ns/1ps
interface edge_if;
  logic level;
  logic rise;
  logic fall;
  modport det (input level, output rise, output fall);
  modport use_side (output level, input rise, input fall);
endinterface

// *** design/edge_detect.sv ***
// Registered rising and falling edge detector with optional two-stage sync
`timescale 1ns/1ps
module edge_detect #(
  parameter bit SYNC = 1'b0
) (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  // Edge strobes
  edge_if.det e
);
  logic s1_reg;
  logic s2_reg;
  logic prev_reg;
  logic cur;

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s1_reg <= 1'b0;
      s2_reg <= 1'b0;
    end else begin
      s1_reg <= e.level;
      s2_reg <= s1_reg;
    end
  end

  // Unsynchronised path still needs one flop to find an edge
  assign cur = SYNC ? s2_reg : e.level;

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      prev_reg <= 1'b0;
    end else begin
      prev_reg <= cur;
    end
  end

  assign e.rise = cur & ~prev_reg;
  assign e.fall = ~cur & prev_reg;
endmodule // edge_detect

// *** design/gated_timer.sv ***
// Gated 16-bit up-counter with clock select, prescaler and gate modes on APB
//
// How it works
// - Clock source field picks counting clock
// - Prescale field divides by 1, 2, 4, 8
// - External clock sync unless sync_disable set
// - Sync disable ignored for internal clocks
// - Counter on runs; off stops, clears toggle
// - Gate enable matters only when counter on
// - Gate polarity picks active level
// - Toggle mode uses flip-flop; off clears it
// - Toggle flip-flop flips on gate rising edge
// - Single-pulse mode controls counter gate
// - Go/done reads armed or measuring state
// - Clearing single-pulse mode clears go/done
// - Gate value shows live gate state
// - Gate source field picks gate input
// - Active gate counts, inactive gate holds
// - Armed pulse counts once, then go/done clears
// - Rollover FFFF to 0000 sets overflow flag
// - Gate value falling edge sets gate flag
`timescale 1ns/1ps
`include "gate_timer_map.svh"
module gated_timer
  import gate_timer_pkg::*;
#(
  parameter int COUNT_W = 16
) (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  // APB slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [3:0] pstrb_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // Clock and gate sources
  input wire logic external_clock_pin_i,
  input wire logic osc_clk_i,
  input wire logic gate_pin_i,
  input wire logic timer0_overflow_i,
  input wire logic synced_comparator_one_out_i,
  input wire logic synced_comparator_two_out_i,
  // Event flags and count
  output logic overflow_flag_o,
  output logic gate_event_flag_o,
  output logic [COUNT_W-1:0] count_o
);
  // Count is served to software as two byte registers, so only 16 bits fit
  if (COUNT_W != 16) begin : g_count_w_check
    $error("gated_timer: COUNT_W must be 16");
  end

  logic [7:0] clk_ctrl_reg;
  logic [7:0] gate_ctrl_reg;
  logic [COUNT_W-1:0] count_reg;
  logic overflow_flag_reg;
  logic gate_event_flag_reg;
  logic toggle_reg;
  logic gval_reg;
  logic [1:0] instr_div_reg;
  logic [2:0] presc_reg;
  sp_state_t sp_reg;
  logic go_done;
  logic [31:0] prdata_reg;
  logic pready_reg;
  logic pslverr_reg;

  // Bus decode
  logic wr_en;
  logic rd_en;
  logic hit;
  assign wr_en = psel_i & penable_i & pwrite_i & pready_reg;
  assign rd_en = psel_i & penable_i & ~pwrite_i & pready_reg;
  assign hit = (paddr_i == `CLK_CTRL_OFFSET) || (paddr_i == `GATE_CTRL_OFFSET) ||
               (paddr_i == `COUNT_LOW_OFFSET) || (paddr_i == `COUNT_HIGH_OFFSET) ||
               (paddr_i == `FLAGS_OFFSET);
  logic wr_clk;
  logic wr_gate;
  logic wr_lo;
  logic wr_hi;
  logic wr_flags;
  assign wr_clk = wr_en & pstrb_i[0] & (paddr_i == `CLK_CTRL_OFFSET);
  assign wr_gate = wr_en & pstrb_i[0] & (paddr_i == `GATE_CTRL_OFFSET);
  assign wr_lo = wr_en & pstrb_i[0] & (paddr_i == `COUNT_LOW_OFFSET);
  assign wr_hi = wr_en & pstrb_i[0] & (paddr_i == `COUNT_HIGH_OFFSET);
  assign wr_flags = wr_en & pstrb_i[0] & (paddr_i == `FLAGS_OFFSET);

  // Field views
  logic [1:0] cs;
  logic [1:0] ps;
  logic sync_dis;
  logic timer_on;
  logic gate_en;
  logic gpol;
  logic gtm;
  logic gspm;
  logic [1:0] gss;
  assign cs = clk_ctrl_reg[`CS_MSB:`CS_LSB];
  assign ps = clk_ctrl_reg[`PS_MSB:`PS_LSB];
  assign sync_dis = clk_ctrl_reg[`SYNC_DIS_BIT];
  assign timer_on = clk_ctrl_reg[`ON_BIT];
  assign gate_en = gate_ctrl_reg[`GE_BIT];
  assign gpol = gate_ctrl_reg[`GPOL_BIT];
  assign gtm = gate_ctrl_reg[`GTM_BIT];
  assign gspm = gate_ctrl_reg[`GSPM_BIT];
  assign gss = gate_ctrl_reg[`GSS_MSB:`GSS_LSB];

  clk_src_t src;
  always_comb begin
    case (cs)
      2'h3: src = CLK_OSC;
      2'h2: src = CLK_EXT;
      2'h1: src = CLK_SYS;
      default: src = CLK_INSTR;
    endcase
  end

  // Edge detectors: external pin both synced and raw, oscillator synced
  edge_if ext_sync_e ();
  edge_if ext_raw_e ();
  edge_if osc_e ();
  edge_if gate_e ();
  edge_if gsrc_e ();
  assign ext_sync_e.level = external_clock_pin_i;
  assign ext_raw_e.level = external_clock_pin_i;
  assign osc_e.level = osc_clk_i;

  edge_detect #(.SYNC(1'b1)) u_ext_sync (
    .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .e(ext_sync_e));
  edge_detect #(.SYNC(1'b0)) u_ext_raw (
    .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .e(ext_raw_e));
  edge_detect #(.SYNC(1'b1)) u_osc (
    .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .e(osc_e));

  // Instruction clock enable: one pulse every four system cycles
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      instr_div_reg <= 2'h0;
    end else begin
      instr_div_reg <= instr_div_reg + 2'h1;
    end
  end

  logic src_tick;
  always_comb begin
    case (src)
      CLK_OSC: src_tick = osc_e.rise;
      CLK_EXT: src_tick = sync_dis ? ext_raw_e.rise : ext_sync_e.rise;
      CLK_SYS: src_tick = 1'b1;
      CLK_INSTR: src_tick = (instr_div_reg == 2'(`INSTR_DIV - 1));
      default: src_tick = 1'b0;
    endcase
  end

  // Prescaler runs only while the timer is on so a stop restarts it cleanly
  logic presc_tick;
  always_comb begin
    case (ps)
      2'h3: presc_tick = src_tick & (presc_reg == 3'h7);
      2'h2: presc_tick = src_tick & (presc_reg[1:0] == 2'h3);
      2'h1: presc_tick = src_tick & presc_reg[0];
      default: presc_tick = src_tick;
    endcase
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      presc_reg <= 3'h0;
    end else if (!timer_on || wr_clk) begin
      presc_reg <= 3'h0;
    end else if (src_tick) begin
      presc_reg <= presc_reg + 3'h1;
    end
  end

  // Gate source select and polarity
  logic gate_raw;
  always_comb begin
    case (gss)
      2'h3: gate_raw = synced_comparator_two_out_i;
      2'h2: gate_raw = synced_comparator_one_out_i;
      2'h1: gate_raw = timer0_overflow_i;
      default: gate_raw = gate_pin_i;
    endcase
  end

  logic gate_pol;
  assign gate_pol = gpol ? gate_raw : ~gate_raw;
  assign gsrc_e.level = gate_pol;
  edge_detect #(.SYNC(1'b0)) u_gsrc (
    .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .e(gsrc_e));

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      toggle_reg <= 1'b0;
    end else if (!timer_on || !gtm) begin
      toggle_reg <= 1'b0;
    end else if (gsrc_e.rise) begin
      toggle_reg <= ~toggle_reg;
    end
  end

  logic gate_stage;
  assign gate_stage = gtm ? toggle_reg : gate_pol;

  // Single pulse: arm on go, open at the next rising gate, close at its trailing edge
  edge_if stage_e ();
  assign stage_e.level = gate_stage;
  edge_detect #(.SYNC(1'b0)) u_stage (
    .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .e(stage_e));

  logic go_set;
  assign go_set = wr_gate & pwdata_i[`GGO_BIT] & pwdata_i[`GSPM_BIT];

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sp_reg <= SP_IDLE;
    end else if (!gspm && !go_set) begin
      // Mode and go written together must arm at once, as the mode bit lands on that edge
      sp_reg <= SP_IDLE;
    end else begin
      case (sp_reg)
        SP_IDLE: if (go_set) sp_reg <= SP_ARMED;
        SP_ARMED: if (stage_e.rise) sp_reg <= SP_RUN;
        SP_RUN: if (stage_e.fall) sp_reg <= SP_IDLE;
        default: sp_reg <= SP_IDLE;
      endcase
    end
  end

  // Go/done is high while armed or measuring, as the state machine shows
  assign go_done = (sp_reg != SP_IDLE);

  logic gate_val;
  assign gate_val = gspm ? ((sp_reg == SP_RUN) & gate_stage) : gate_stage;

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      gval_reg <= 1'b0;
    end else begin
      gval_reg <= gate_val;
    end
  end

  assign gate_e.level = gval_reg;
  edge_detect #(.SYNC(1'b0)) u_gval (
    .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .e(gate_e));

  // Counter
  logic count_en;
  assign count_en = timer_on & presc_tick & (~gate_en | gval_reg);

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      count_reg <= '0;
    end else if (wr_lo) begin
      count_reg[7:0] <= pwdata_i[7:0];
    end else if (wr_hi) begin
      count_reg[15:8] <= pwdata_i[7:0];
    end else if (count_en) begin
      count_reg <= count_reg + 16'h0001;
    end
  end

  logic rollover;
  assign rollover = count_en & ~wr_lo & ~wr_hi & (count_reg == 16'hFFFF);

  // Flags: write one to clear, a set in the same cycle wins
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      overflow_flag_reg <= 1'b0;
    end else if (rollover) begin
      overflow_flag_reg <= 1'b1;
    end else if (wr_flags & pwdata_i[`OVF_FLAG_BIT]) begin
      overflow_flag_reg <= 1'b0;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      gate_event_flag_reg <= 1'b0;
    end else if (gate_e.fall) begin
      gate_event_flag_reg <= 1'b1;
    end else if (wr_flags & pwdata_i[`GATE_FLAG_BIT]) begin
      gate_event_flag_reg <= 1'b0;
    end
  end

  // Control registers
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      clk_ctrl_reg <= `CLK_CTRL_RESET;
    end else if (wr_clk) begin
      clk_ctrl_reg <= pwdata_i[7:0] & `CLK_CTRL_WMASK;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      gate_ctrl_reg <= `GATE_CTRL_RESET;
    end else if (wr_gate) begin
      gate_ctrl_reg <= {pwdata_i[7:4], 2'b00, pwdata_i[1:0]};
    end
  end

  // APB: one wait state so every access completes in two access cycles
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pready_reg <= 1'b0;
    end else begin
      pready_reg <= psel_i & penable_i & ~pready_reg;
    end
  end

  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (paddr_i)
      `CLK_CTRL_OFFSET: rd_mux[7:0] = clk_ctrl_reg;
      `GATE_CTRL_OFFSET: rd_mux[7:0] = {gate_ctrl_reg[7:4], go_done, gval_reg,
                                        gate_ctrl_reg[1:0]};
      `COUNT_LOW_OFFSET: rd_mux[7:0] = count_reg[7:0];
      `COUNT_HIGH_OFFSET: rd_mux[7:0] = count_reg[15:8];
      `FLAGS_OFFSET: rd_mux[1:0] = {gate_event_flag_reg, overflow_flag_reg};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      prdata_reg <= 32'h0000_0000;
      pslverr_reg <= 1'b0;
    end else if (psel_i & penable_i & ~pready_reg) begin
      prdata_reg <= pwrite_i ? 32'h0000_0000 : rd_mux;
      pslverr_reg <= ~hit;
    end else begin
      pslverr_reg <= 1'b0;
    end
  end

  // Reads have no side effect here, so the read strobe is kept only for symmetry
  logic unused_rd;
  assign unused_rd = rd_en;

  assign prdata_o = prdata_reg;
  assign pready_o = pready_reg;
  assign pslverr_o = pslverr_reg;
  assign overflow_flag_o = overflow_flag_reg;
  assign gate_event_flag_o = gate_event_flag_reg;
  assign count_o = count_reg;
endmodule // gated_timer

// *** tb/gated_timer_properties.sv ***
// Port-level properties of the gated timer
`timescale 1ns/1ps
module gated_timer_properties #(
  parameter int COUNT_W = 16
) (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic psel_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [31:0] prdata_o,
  input wire logic pready_o,
  input wire logic pslverr_o,
  input wire logic overflow_flag_o,
  input wire logic [COUNT_W-1:0] count_o
);
  logic on_reg;
  // Shadow of the on bit, taken at the same edge the write lands
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      on_reg <= 1'b0;
    end else if (pready_o && pwrite_i && paddr_i == 12'h000) begin
      on_reg <= pwdata_i[0];
    end
  end
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);
  step_by_one_a: assert property ($changed(count_o) && !$past(pready_o)
    |-> count_o == $past(count_o) + 1'b1) else $error("count jumped");
  off_holds_a: assert property (!$past(on_reg) && !$past(pready_o) |-> $stable(count_o))
    else $error("count moved while off");
  wrap_sets_flag_a: assert property (count_o == 16'h0000 && $past(count_o) == 16'hFFFF
    && !$past(pready_o) |-> overflow_flag_o) else $error("no overflow flag");
  flag_clear_a: assert property ($fell(overflow_flag_o) |-> $past(pready_o && pwrite_i
    && paddr_i == 12'h010 && pwdata_i[0])) else $error("flag lost");
  upper_zero_a: assert property (pready_o |-> prdata_o[31:8] == 24'h000000)
    else $error("upper read bits set");
  reserved_zero_a: assert property (pready_o && !pwrite_i && paddr_i == 12'h000
    |-> prdata_o[3] == 1'b0 && prdata_o[1] == 1'b0) else $error("reserved bit set");
  go_needs_mode_a: assert property (pready_o && !pwrite_i && paddr_i == 12'h004
    && prdata_o[3] |-> prdata_o[4]) else $error("go without mode");
  unmapped_error_a: assert property (pready_o && paddr_i > 12'h010
    |-> pslverr_o && prdata_o == 32'h0) else $error("unmapped access accepted");
endmodule // gated_timer_properties

// *** tb/gate_source_model.sv ***
// Far-side sources: external count clock, oscillator and gate inputs
`timescale 1ns/1ps
module gate_source_model (
  // Clock
  input wire logic core_clk_i,
  // Controls from the bench
  input wire logic ext_run_i,
  input wire logic [3:0] gate_lvl_i,
  // Source outputs
  output logic external_clock_pin_o = 1'b0,
  output logic osc_clk_o = 1'b0,
  output logic [3:0] gate_src_o = 4'h0
);
  logic [3:0] div_reg = 4'h0;
  always @(posedge core_clk_i) begin
    div_reg <= div_reg + 4'h1;
    // Pin rests low outside bursts so no stray edge is counted
    external_clock_pin_o <= ext_run_i & div_reg[2];
    osc_clk_o <= div_reg[3];
    gate_src_o <= gate_lvl_i;
  end
endmodule // gate_source_model

// *** tb/tb_top.sv ***
// Self-checking bench for the gated timer
`timescale 1ns/1ps
`include "gate_timer_map.svh"
module tb_top;
  logic core_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic psel_i = 1'b0;
  logic penable_i = 1'b0;
  logic pwrite_i = 1'b0;
  logic [11:0] paddr_i = 12'h000;
  logic [31:0] pwdata_i = 32'h0;
  logic [31:0] prdata_o;
  logic pready_o, pslverr_o, ext_clk, osc_clk, ovf, gflag;
  logic ext_run = 1'b0;
  logic [3:0] lvl = 4'h0;
  logic [3:0] src;
  logic [15:0] count_o;
  logic [7:0] lfsr = 8'h31;
  logic [31:0] exp_q[$];
  int tol_q[$];
  int n_fail = 0;
  int n_checks = 0;
  int n, dv, act;
  initial forever #25 core_clk_i = ~core_clk_i;
  gate_source_model gate_source_model_i (.core_clk_i(core_clk_i), .ext_run_i(ext_run),
    .gate_lvl_i(lvl), .external_clock_pin_o(ext_clk), .osc_clk_o(osc_clk), .gate_src_o(src));
  gated_timer gated_timer_i (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
    .pstrb_i(4'hF), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .external_clock_pin_i(ext_clk), .osc_clk_i(osc_clk), .gate_pin_i(src[0]),
    .timer0_overflow_i(src[1]), .synced_comparator_one_out_i(src[2]),
    .synced_comparator_two_out_i(src[3]), .overflow_flag_o(ovf), .gate_event_flag_o(gflag),
    .count_o(count_o));
  function automatic logic [7:0] nxt(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    psel_i <= 1'b1;
    pwrite_i <= wr;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge core_clk_i);
    penable_i <= 1'b1;
    do @(posedge core_clk_i); while (pready_o !== 1'b1);
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    @(posedge core_clk_i);
  endtask
  // Sticky flag outputs compared straight at the pins
  task automatic chk_flags(input logic [1:0] e);
    n_checks++;
    if ({gflag, ovf} !== e) begin
      n_fail++;
      $display("unexpected at %0t: got %h expected %h", $time, {gflag, ovf}, e);
    end
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e, input int tol);
    exp_q.push_back(e);
    tol_q.push_back(tol);
    apb(1'b0, a, 32'h0);
  endtask
  task automatic run(input logic [7:0] ctl, input int cyc);
    apb(1'b1, `CLK_CTRL_OFFSET, {24'h0, ctl | 8'h01});
    repeat (cyc) @(posedge core_clk_i);
    apb(1'b1, `CLK_CTRL_OFFSET, {24'h0, ctl});
  endtask
  // Result watcher: oldest note is matched against each read answer
  always @(posedge core_clk_i) begin
    logic [31:0] e;
    int t, d;
    if (pready_o === 1'b1 && pwrite_i === 1'b0 && exp_q.size() > 0) begin
      e = exp_q.pop_front();
      t = tol_q.pop_front();
      d = int'(prdata_o) - int'(e);
      n_checks++;
      if ($isunknown(prdata_o) || d > t || d < -t) begin
        n_fail++;
        $display("unexpected at %0t: got %h expected %h", $time, prdata_o, e);
      end
    end
  end
  // Whole run needs about 6000 cycles; this allows six times that
  initial begin
    #1800us;
    n_fail++;
    report_and_stop;
  end
  initial begin
    repeat (20) @(posedge core_clk_i);
    rst_n_i <= 1'b1;
    @(posedge core_clk_i);
    rd(`CLK_CTRL_OFFSET, 32'h00, 0);
    rd(`GATE_CTRL_OFFSET, 32'h04, 0);
    rd(`FLAGS_OFFSET, 32'h00, 0);
    rd(12'h020, 32'h00, 0);
    apb(1'b1, `CLK_CTRL_OFFSET, 32'hFE);
    rd(`CLK_CTRL_OFFSET, 32'hF4, 0);
    $display("test registers done");
    for (int m = 0; m < 32; m++) begin
      lfsr = nxt(lfsr);
      n = 96 + lfsr[5:0];
      dv = (m[4:3] == 2'b00) ? 4 : (m[4:3] == 2'b01) ? 1 : (m[4:3] == 2'b10) ? 8 : 16;
      dv = dv << m[2:1];
      apb(1'b1, `COUNT_LOW_OFFSET, 32'h0);
      ext_run <= 1'b1;
      run({m[4:1], 1'b0, m[0], 2'b00}, n);
      ext_run <= 1'b0;
      rd(`COUNT_LOW_OFFSET, (n + 3) / dv, 2);
    end
    $display("test clock select done");
    for (int m = 0; m < 8; m++) begin
      lfsr = nxt(lfsr);
      act = (lfsr[0] == m[0]);
      lvl <= lfsr[0] ? (4'h1 << m[2:1]) : ~(4'h1 << m[2:1]);
      apb(1'b1, `GATE_CTRL_OFFSET, {24'h0, 1'b1, m[0], 4'h0, m[2:1]});
      apb(1'b1, `COUNT_LOW_OFFSET, 32'h0);
      run(8'h40, 60);
      rd(`COUNT_LOW_OFFSET, act ? 63 : 0, act ? 2 : 0);
      rd(`GATE_CTRL_OFFSET, {24'h0, 1'b1, m[0], 3'h0, act[0], m[2:1]}, 0);
    end
    $display("test gate select done");
    apb(1'b1, `GATE_CTRL_OFFSET, 32'h40);
    lvl <= 4'h1;
    apb(1'b1, `FLAGS_OFFSET, 32'h3);
    lvl <= 4'h0;
    repeat (4) @(posedge core_clk_i);
    rd(`FLAGS_OFFSET, 32'h2, 0);
    chk_flags(2'b10);
    apb(1'b1, `FLAGS_OFFSET, 32'h3);
    apb(1'b1, `COUNT_LOW_OFFSET, 32'hFE);
    apb(1'b1, `COUNT_HIGH_OFFSET, 32'hFF);
    run(8'h40, 8);
    rd(`FLAGS_OFFSET, 32'h1, 0);
    rd(`COUNT_HIGH_OFFSET, 32'h0, 0);
    chk_flags(2'b01);
    apb(1'b1, `FLAGS_OFFSET, 32'h3);
    rd(`FLAGS_OFFSET, 32'h0, 0);
    chk_flags(2'b00);
    $display("test flags done");
    apb(1'b1, `GATE_CTRL_OFFSET, 32'hE0);
    apb(1'b1, `COUNT_LOW_OFFSET, 32'h0);
    apb(1'b1, `CLK_CTRL_OFFSET, 32'h41);
    lvl <= 4'h1;
    repeat (4) @(posedge core_clk_i);
    lvl <= 4'h0;
    repeat (40) @(posedge core_clk_i);
    apb(1'b1, `CLK_CTRL_OFFSET, 32'h40);
    rd(`COUNT_LOW_OFFSET, 46, 3);
    apb(1'b1, `GATE_CTRL_OFFSET, 32'hD0);
    apb(1'b1, `GATE_CTRL_OFFSET, 32'hD8);
    rd(`GATE_CTRL_OFFSET, 32'hD8, 0);
    apb(1'b1, `COUNT_LOW_OFFSET, 32'h0);
    apb(1'b1, `CLK_CTRL_OFFSET, 32'h41);
    for (int p = 0; p < 2; p++) begin
      lvl <= 4'h1;
      repeat (10) @(posedge core_clk_i);
      lvl <= 4'h0;
      repeat (10) @(posedge core_clk_i);
    end
    apb(1'b1, `CLK_CTRL_OFFSET, 32'h40);
    rd(`COUNT_LOW_OFFSET, 10, 2);
    rd(`GATE_CTRL_OFFSET, 32'hD0, 0);
    apb(1'b1, `GATE_CTRL_OFFSET, 32'hD8);
    apb(1'b1, `GATE_CTRL_OFFSET, 32'hC0);
    rd(`GATE_CTRL_OFFSET, 32'hC0, 0);
    $display("test toggle and single pulse done");
    report_and_stop;
  end
endmodule // tb_top
bind gated_timer gated_timer_properties #(.COUNT_W(COUNT_W)) gated_timer_properties_i (
  .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .psel_i(psel_i), .pwrite_i(pwrite_i),
  .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
  .pslverr_o(pslverr_o), .overflow_flag_o(overflow_flag_o), .count_o(count_o));
